// ### lfs_filter_ctrl.sv
// lock-in low-pass chain with setting control, sync filter and readback
// assumes detector samples, slot ticks and reference frequency come from
// logic on clk_sys_i; only the reserve overload pin is asynchronous
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ns
module lfs_filter_ctrl #(
    parameter int W = 24,
    parameter int FRAC = 16,
    parameter int DISP_CYC = lfs_pkg::LFS_DISP_CYC,
    parameter int AR_SETTLE_CYC = lfs_pkg::LFS_AR_SETTLE_CYC
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // reference and detector stream
    input wire logic [23:0] ref_freq_i,
    input wire logic slot_tick_i,
    input wire logic sample_vld_i,
    input wire logic signed [W-1:0] det_x_i,
    input wire logic reserve_overload_flag_i,
    // filtered outputs and indications
    output logic signed [W-1:0] direct_x_o,
    output logic direct_vld_o,
    output logic signed [W-1:0] disp_x_o,
    output logic time_constant_changed_msg_o,
    output logic lowpass_overload_flag_o,
    output logic sync_active_o,
    output logic range_hi_o
);
    localparam int AW = W + FRAC;
    localparam int SW = W + lfs_pkg::LFS_SLOTS_LOG;
    localparam int NSL = 1 << lfs_pkg::LFS_SLOTS_LOG;

    lfs_pkg::lfs_ctrl_t ctrl_r;
    lfs_pkg::lfs_ar_state_t ar_st_r;
    logic [4:0] tc_r;
    logic [15:0] harm_r;
    logic range_hi_r;
    logic sync_act_r;
    logic tc_chg_r;
    logic lp_ovl_r;
    logic ro_s1_r;
    logic ro_s2_r;
    logic [31:0] rdata_r;
    logic [15:0] ar_cnt_r;
    logic [15:0] disp_cnt_r;
    logic signed [W-1:0] direct_r;
    logic direct_vld_r;
    logic signed [W-1:0] disp_r;
    logic [lfs_pkg::LFS_SLOTS_LOG-1:0] ptr_r;
    logic [lfs_pkg::LFS_SLOTS_LOG:0] fill_r;
    logic signed [SW-1:0] ssum_r;
    logic signed [W-1:0] savg_r;
    logic signed [W-1:0] smem [NSL];

    // decode
    wire logic ctrl_wr = wr_i && (addr_i == lfs_pkg::LFS_A_CTRL);
    wire logic tc_wr = wr_i && (addr_i == lfs_pkg::LFS_A_TC);
    wire logic harm_wr = wr_i && (addr_i == lfs_pkg::LFS_A_HARM);
    wire logic stat_wr = wr_i && (addr_i == lfs_pkg::LFS_A_STAT);
    wire lfs_pkg::lfs_ctrl_t wctrl = lfs_pkg::lfs_ctrl_t'(wdata_i);
    wire logic ar_idle = (ar_st_r == lfs_pkg::LFS_AR_IDLE);
    wire logic ar_go = ctrl_wr && wctrl.ar_go && ar_idle;

    // reserve and dc gain
    wire logic [4:0] sens_w = (ctrl_r.sens > lfs_pkg::LFS_SENS_MAX) ?
        lfs_pkg::LFS_SENS_MAX : ctrl_r.sens;
    wire logic [7:0] res_db = (ctrl_r.mode == lfs_pkg::LFS_MODE_LOW) ?
        lfs_pkg::LFS_RES_LOW[sens_w] :
        (ctrl_r.mode == lfs_pkg::LFS_MODE_NORM) ?
        lfs_pkg::LFS_RES_NORM[sens_w] : lfs_pkg::LFS_RES_HIGH[sens_w];
    wire logic [8:0] dc_gain = {1'b0, res_db} +
        {1'b0, lfs_pkg::LFS_EXP_DB[ctrl_r.expand]};

    // count of bounds at or below the gain gives the minimum index
    function automatic logic [4:0] min_tc_idx(input logic [8:0] g,
                                              input logic [1:0] sl);
        logic [9:0] bnd;
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 14; i++) begin
            bnd = {2'b00, lfs_pkg::LFS_GB_FIRST[sl]} +
                10'({2'b00, lfs_pkg::LFS_GB_STEP[sl]} * 10'(i));
            if ((5'(i) < lfs_pkg::LFS_GB_LAST[sl]) && ({1'b0, g} >= bnd)) begin
                n = 5'(i + 1);
            end
        end
        return n;
    endfunction

    wire logic [4:0] min_idx = min_tc_idx(dc_gain, ctrl_r.slope);
    wire logic [4:0] max_idx = range_hi_r ? lfs_pkg::LFS_TC_MAX_HI :
        lfs_pkg::LFS_TC_MAX_LO;

    // detection frequency and hysteresis
    wire logic [39:0] fdet = ref_freq_i * harm_r;
    wire logic f_up = fdet > lfs_pkg::LFS_F_UP;
    wire logic f_dn = fdet < lfs_pkg::LFS_F_DN;

    // time constant update, a write has priority over automatic moves
    wire logic [4:0] tc_req = wdata_i[4:0];
    wire logic tc_req_ok = tc_req <= max_idx;
    wire logic [4:0] tc_req_v = (tc_req < min_idx) ? min_idx : tc_req;
    wire logic tc_over = tc_r > max_idx;
    wire logic tc_under = tc_r < min_idx;
    wire logic tc_auto = !tc_wr && (tc_over || tc_under);
    wire logic [4:0] tc_nxt = tc_wr ? (tc_req_ok ? tc_req_v : tc_r) :
        tc_over ? max_idx : tc_under ? min_idx : tc_r;
    wire logic tc_chg_nxt = tc_auto ? 1'b1 :
        (stat_wr && wdata_i[2]) ? 1'b0 : tc_chg_r;

    // time constant readback code
    wire logic [3:0] tc_n = 4'(tc_r[4:1]) + 4'h1;
    wire lfs_pkg::lfs_tc_code_t tc_code = '{rsv: '0,
        unit: 2'(tc_n / 4'h3), decade: 2'(tc_n % 4'h3),
        mant3: tc_r[0], rsv_lo: '0, idx: tc_r};

    // auto reserve sequencing
    wire logic ar_done = ar_cnt_r == 16'(AR_SETTLE_CYC - 1);
    wire logic ar_step = (ar_st_r == lfs_pkg::LFS_AR_CHECK) && ro_s2_r &&
        (ctrl_r.mode != lfs_pkg::LFS_MODE_HIGH);
    wire logic [1:0] mode_nxt = ar_go ? lfs_pkg::LFS_MODE_LOW :
        ar_step ? 2'(ctrl_r.mode + 2'h1) : ctrl_r.mode;

    // read mux
    wire lfs_pkg::lfs_stat_t stat_w = '{rsv_hi: '0, max_idx: max_idx,
        min_idx: min_idx, res_db: res_db, rsv_lo: '0, ar_busy: !ar_idle,
        lp_ovl: lp_ovl_r, tc_chg: tc_chg_r, sync_act: sync_act_r,
        range_hi: range_hi_r};
    wire logic [31:0] rd_mux =
        (addr_i == lfs_pkg::LFS_A_CTRL) ? 32'(ctrl_r) :
        (addr_i == lfs_pkg::LFS_A_TC) ? 32'(tc_code) :
        (addr_i == lfs_pkg::LFS_A_HARM) ? {16'h0000, harm_r} :
        (addr_i == lfs_pkg::LFS_A_STAT) ? 32'(stat_w) :
        (addr_i == lfs_pkg::LFS_A_GAIN) ? {23'h000000, dc_gain} : 32'h0;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_r <= lfs_pkg::LFS_CTRL_RST;
        end else begin
            if (ctrl_wr) begin
                ctrl_r <= '{rsv_hi: '0, ar_go: 1'b0, sync_en: wctrl.sync_en,
                    expand: wctrl.expand, slope: wctrl.slope, rsv_lo: 1'b0,
                    mode: ar_idle ? (ar_go ? mode_nxt : wctrl.mode) :
                    ctrl_r.mode, sens: wctrl.sens};
            end else begin
                ctrl_r.mode <= mode_nxt;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ar_st_r <= lfs_pkg::LFS_AR_IDLE;
            ar_cnt_r <= 16'h0000;
        end else begin
            case (ar_st_r)
                lfs_pkg::LFS_AR_IDLE: begin
                    ar_cnt_r <= 16'h0000;
                    if (ar_go) begin
                        ar_st_r <= lfs_pkg::LFS_AR_SETTLE;
                    end
                end
                lfs_pkg::LFS_AR_SETTLE: begin
                    ar_cnt_r <= ar_cnt_r + 16'h0001;
                    if (ar_done) begin
                        ar_st_r <= lfs_pkg::LFS_AR_CHECK;
                    end
                end
                lfs_pkg::LFS_AR_CHECK: begin
                    ar_cnt_r <= 16'h0000;
                    ar_st_r <= ar_step ? lfs_pkg::LFS_AR_SETTLE :
                        lfs_pkg::LFS_AR_IDLE;
                end
                default: begin
                    ar_st_r <= lfs_pkg::LFS_AR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tc_r <= lfs_pkg::LFS_TC_RST;
            harm_r <= lfs_pkg::LFS_HARM_RST;
            tc_chg_r <= 1'b0;
            range_hi_r <= 1'b0;
            sync_act_r <= 1'b0;
            ro_s1_r <= 1'b0;
            ro_s2_r <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            tc_r <= tc_nxt;
            tc_chg_r <= tc_chg_nxt;
            if (harm_wr) begin
                harm_r <= (wdata_i[15:0] == 16'h0) ? 16'h0001 : wdata_i[15:0];
            end
            range_hi_r <= f_up ? 1'b1 : f_dn ? 1'b0 : range_hi_r;
            sync_act_r <= ctrl_r.sync_en && !range_hi_r;
            ro_s1_r <= reserve_overload_flag_i;
            ro_s2_r <= ro_s1_r;
            rdata_r <= rd_i ? rd_mux : 32'h0;
        end
    end

    // low-pass poles; a stage above the slope count runs at minimum tc
    wire logic [3:0] tc_k = (tc_r > 5'(lfs_pkg::LFS_K_MAX)) ?
        lfs_pkg::LFS_K_MAX : tc_r[3:0];
    wire logic [3:0] min_k = min_idx[3:0];
    // expand gain ahead of the first pole, as the nearest power of two
    wire logic [2:0] exp_sh = (ctrl_r.expand == 2'h0) ? 3'h0 :
        (ctrl_r.expand == 2'h1) ? 3'h3 : 3'h7;
    wire logic signed [AW+7:0] g_in = (AW+8)'(det_x_i) <<< (FRAC + exp_sh);
    wire logic g_ov = (g_in[AW+7:AW-1] != {9{1'b0}}) &&
        (g_in[AW+7:AW-1] != {9{1'b1}});
    wire logic signed [AW-1:0] g_sat = !g_ov ? g_in[AW-1:0] :
        g_in[AW+7] ? {1'b1, {(AW-1){1'b0}}} : {1'b0, {(AW-1){1'b1}}};
    logic signed [AW-1:0] pole_y [lfs_pkg::LFS_POLES];
    logic [lfs_pkg::LFS_POLES-1:0] pole_ovf;

    for (genvar i = 0; i < lfs_pkg::LFS_POLES; i++) begin : g_pole
        wire logic signed [AW-1:0] p_in;
        if (i == 0) begin : g_first
            assign p_in = g_sat;
        end else if (i == 2) begin : g_mid
            assign p_in = sync_act_r ? {savg_r, {FRAC{1'b0}}} :
                pole_y[1];
        end else begin : g_next
            assign p_in = pole_y[i-1];
        end
        wire logic [3:0] p_k = (2'(i) <= ctrl_r.slope) ? tc_k : min_k;
        wire logic signed [AW:0] p_diff = {p_in[AW-1], p_in} -
            {pole_y[i][AW-1], pole_y[i]};
        wire logic signed [AW:0] p_sum =
            $signed({pole_y[i][AW-1], pole_y[i]}) + (p_diff >>> p_k);
        wire logic p_ov = p_sum[AW] != p_sum[AW-1];
        wire logic signed [AW-1:0] p_sat = !p_ov ? p_sum[AW-1:0] :
            p_sum[AW] ? {1'b1, {(AW-1){1'b0}}} : {1'b0, {(AW-1){1'b1}}};
        assign pole_ovf[i] = p_ov || ((i == 0) && g_ov);
        always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                pole_y[i] <= '0;
            end else if (sample_vld_i) begin
                pole_y[i] <= p_sat;
            end
        end
    end

    // synchronous filter, running sum over the last 128 slots
    wire logic signed [W-1:0] s_new = pole_y[1][AW-1:FRAC];
    wire logic s_full = fill_r[lfs_pkg::LFS_SLOTS_LOG];
    wire logic signed [W-1:0] s_old = s_full ? smem[ptr_r] : '0;
    wire logic signed [SW-1:0] ssum_nxt = ssum_r + SW'(s_new) - SW'(s_old);

    always_ff @(posedge clk_sys_i) begin
        if (slot_tick_i) begin
            smem[ptr_r] <= s_new;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ptr_r <= '0;
            fill_r <= '0;
            ssum_r <= '0;
            savg_r <= '0;
        end else if (!sync_act_r) begin
            ptr_r <= '0;
            fill_r <= '0;
            ssum_r <= '0;
            savg_r <= '0;
        end else if (slot_tick_i) begin
            ptr_r <= ptr_r + 1'b1;
            fill_r <= s_full ? fill_r : fill_r + 1'b1;
            ssum_r <= ssum_nxt;
            savg_r <= ssum_nxt[SW-1:lfs_pkg::LFS_SLOTS_LOG];
        end
    end

    // outputs
    wire logic disp_tick = disp_cnt_r == 16'(DISP_CYC - 1);

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            disp_cnt_r <= 16'h0000;
            direct_r <= '0;
            direct_vld_r <= 1'b0;
            disp_r <= '0;
            lp_ovl_r <= 1'b0;
        end else begin
            disp_cnt_r <= disp_tick ? 16'h0000 : disp_cnt_r + 16'h0001;
            direct_vld_r <= sample_vld_i;
            if (sample_vld_i) begin
                direct_r <= pole_y[3][AW-1:FRAC];
                lp_ovl_r <= |pole_ovf;
            end
            if (disp_tick) begin
                disp_r <= pole_y[3][AW-1:FRAC];
            end
        end
    end

    assign rdata_o = rdata_r;
    assign direct_x_o = direct_r;
    assign direct_vld_o = direct_vld_r;
    assign disp_x_o = disp_r;
    assign time_constant_changed_msg_o = tc_chg_r;
    assign lowpass_overload_flag_o = lp_ovl_r;
    assign sync_active_o = sync_act_r;
    assign range_hi_o = range_hi_r;

    // checks
    sequence s_clamp_cause;
        range_hi_r && (tc_r > lfs_pkg::LFS_TC_MAX_HI) && !tc_wr;
    endsequence
    sequence s_clamp_effect;
        (tc_r == lfs_pkg::LFS_TC_MAX_HI) && tc_chg_r;
    endsequence

    property p_res_corner;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        ctrl_wr && !wctrl.ar_go && ar_idle && (wctrl.sens == 5'h1A) &&
        (wctrl.mode == lfs_pkg::LFS_MODE_HIGH) |=> (res_db == 8'hAE);
    endproperty
    a_res_corner: assert property (p_res_corner)
        else $error("reserve at 2 nV high is not 174 dB");

    property p_range_up;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (fdet > 40'h00_0000_4F58) |=> range_hi_r;
    endproperty
    a_range_up: assert property (p_range_up)
        else $error("range did not go high above 203.12 Hz");

    property p_range_hold;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (fdet >= 40'h00_0000_4DD1) && (fdet <= 40'h00_0000_4F58) |=>
        (range_hi_r == $past(range_hi_r));
    endproperty
    a_range_hold: assert property (p_range_hold)
        else $error("range moved inside the hysteresis band");

    property p_clamp;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        s_clamp_cause |=> s_clamp_effect;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("time constant not clamped to 30 s");

    property p_tc_max;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        range_hi_r && $past(range_hi_r) && !$past(tc_wr) |->
        ##1 (tc_r <= 5'h0D);
    endproperty
    a_tc_max: assert property (p_tc_max)
        else $error("time constant above 30 s in high range");

    property p_force_min;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        !tc_wr && (tc_r < min_idx) && !tc_over |=>
        (tc_r == $past(min_idx)) && tc_chg_r;
    endproperty
    a_force_min: assert property (p_force_min)
        else $error("time constant not forced up to minimum");

    property p_sync_status;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        ctrl_r.sync_en && !range_hi_r ##1 ctrl_r.sync_en && !range_hi_r
        |-> sync_active_o;
    endproperty
    a_sync_status: assert property (p_sync_status)
        else $error("sync active missing below the low threshold");

    property p_slot_walk;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        sync_act_r && slot_tick_i |=>
        (ptr_r == $past(ptr_r) + 7'h01) || !sync_act_r;
    endproperty
    a_slot_walk: assert property (p_slot_walk)
        else $error("slot pointer did not advance");

    property p_ovl;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        sample_vld_i && (|pole_ovf) |=> lowpass_overload_flag_o;
    endproperty
    a_ovl: assert property (p_ovl)
        else $error("stage overflow not flagged");

    property p_ar_start;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        ar_go |=> (ctrl_r.mode == lfs_pkg::LFS_MODE_LOW) &&
        (ar_st_r == lfs_pkg::LFS_AR_SETTLE);
    endproperty
    a_ar_start: assert property (p_ar_start)
        else $error("auto reserve did not start from low noise");

    wire logic signed [W-1:0] pole3_top = pole_y[3][AW-1:FRAC];
    property p_disp;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        disp_tick |=> (disp_x_o == $past(pole3_top));
    endproperty
    a_disp: assert property (p_disp)
        else $error("display output not loaded on its tick");

endmodule

// ### lfs_pkg.sv
// constants, field layouts and types of the lock-in filter setting block
// assumes a 10 MHz system clock and frequencies given in 0.01 Hz units
package lfs_pkg;

    // register word addresses
    localparam logic [3:0] LFS_A_CTRL = 4'h0;
    localparam logic [3:0] LFS_A_TC = 4'h1;
    localparam logic [3:0] LFS_A_HARM = 4'h2;
    localparam logic [3:0] LFS_A_STAT = 4'h3;
    localparam logic [3:0] LFS_A_GAIN = 4'h4;

    typedef enum logic [1:0] {
        LFS_MODE_LOW = 2'b00,
        LFS_MODE_NORM = 2'b01,
        LFS_MODE_HIGH = 2'b10
    } lfs_mode_t;

    typedef enum logic [1:0] {
        LFS_AR_IDLE = 2'b00,
        LFS_AR_SETTLE = 2'b01,
        LFS_AR_CHECK = 2'b10
    } lfs_ar_state_t;

    typedef struct packed {
        logic [17:0] rsv_hi;
        logic ar_go;
        logic sync_en;
        logic [1:0] expand;
        logic [1:0] slope;
        logic rsv_lo;
        logic [1:0] mode;
        logic [4:0] sens;
    } lfs_ctrl_t;

    typedef struct packed {
        logic [5:0] rsv_hi;
        logic [4:0] max_idx;
        logic [4:0] min_idx;
        logic [7:0] res_db;
        logic [2:0] rsv_lo;
        logic ar_busy;
        logic lp_ovl;
        logic tc_chg;
        logic sync_act;
        logic range_hi;
    } lfs_stat_t;

    // time constant readback: 1 or 3, times 1/10/100, unit us/ms/s/ks
    typedef struct packed {
        logic [18:0] rsv;
        logic [1:0] unit;
        logic [1:0] decade;
        logic mant3;
        logic [2:0] rsv_lo;
        logic [4:0] idx;
    } lfs_tc_code_t;

    localparam logic [31:0] LFS_CTRL_RST = 32'h0000_0120;
    localparam logic [4:0] LFS_TC_RST = 5'h08;
    localparam logic [15:0] LFS_HARM_RST = 16'h0001;
    localparam logic [4:0] LFS_SENS_MAX = 5'h1A;

    // range hysteresis, 203.12 Hz up and 199.21 Hz down
    localparam logic [39:0] LFS_F_UP = 40'h00_0000_4F58;
    localparam logic [39:0] LFS_F_DN = 40'h00_0000_4DD1;

    // index 0 is 10 us, odd indices are the 3x steps
    localparam logic [4:0] LFS_TC_MAX_HI = 5'h0D;
    localparam logic [4:0] LFS_TC_MAX_LO = 5'h13;
    localparam logic [3:0] LFS_K_MAX = 4'hF;

    // per slope: first gain bound, bound step, last min index
    localparam logic [7:0] LFS_GB_FIRST [4] = '{8'h2D, 8'h37, 8'h3E, 8'h48};
    localparam logic [7:0] LFS_GB_STEP [4] = '{8'h0A, 8'h14, 8'h1E, 8'h28};
    localparam logic [4:0] LFS_GB_LAST [4] = '{5'h0D, 5'h06, 5'h04, 5'h03};
    localparam logic [7:0] LFS_EXP_DB [4] = '{8'h00, 8'h14, 8'h28, 8'h28};

    // actual reserve in dB, index 0 is 1 V full scale
    localparam logic [7:0] LFS_RES_LOW [27] = '{
        8'h00, 8'h06, 8'h04, 8'h00, 8'h06, 8'h04, 8'h00, 8'h06, 8'h04,
        8'h0A, 8'h10, 8'h18, 8'h1E, 8'h24, 8'h2C, 8'h32, 8'h38, 8'h40,
        8'h46, 8'h4C, 8'h54, 8'h5A, 8'h60, 8'h68, 8'h6E, 8'h74, 8'h7C};
    localparam logic [7:0] LFS_RES_NORM [27] = '{
        8'h00, 8'h06, 8'h0E, 8'h0A, 8'h10, 8'h18, 8'h14, 8'h1A, 8'h22,
        8'h28, 8'h2E, 8'h36, 8'h3C, 8'h42, 8'h4A, 8'h50, 8'h56, 8'h5E,
        8'h64, 8'h6A, 8'h72, 8'h78, 8'h7E, 8'h86, 8'h8C, 8'h92, 8'h9A};
    localparam logic [7:0] LFS_RES_HIGH [27] = '{
        8'h00, 8'h06, 8'h0E, 8'h14, 8'h1A, 8'h22, 8'h28, 8'h2E, 8'h36,
        8'h3C, 8'h42, 8'h4A, 8'h50, 8'h56, 8'h5E, 8'h64, 8'h6A, 8'h72,
        8'h78, 8'h7E, 8'h86, 8'h8C, 8'h92, 8'h9A, 8'hA0, 8'hA6, 8'hAE};

    localparam int LFS_POLES = 4;
    localparam int LFS_SLOTS_LOG = 7;
    localparam int LFS_CLK_NS = 100;
    localparam int LFS_DISP_NS = 1953125;
    localparam int LFS_DISP_CYC = LFS_DISP_NS / LFS_CLK_NS;
    localparam int LFS_AR_SETTLE_NS = 100000;
    localparam int LFS_AR_SETTLE_CYC = LFS_AR_SETTLE_NS / LFS_CLK_NS;

endpackage

// ### tb_top.sv
// self-checking testbench of the lock-in filter setting block
// assumes the block alone, reached through its register port
`timescale 1ns/1ns
module tb_top;
    typedef struct {
        logic [31:0] ctrl;
        logic [7:0] res;
        logic [8:0] gain;
    } lfs_row_t;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [23:0] ref_f = 24'h0003E8;
    logic tick = 1'b0;
    logic svld = 1'b0;
    logic signed [23:0] det = 24'sh000100;
    logic rovl = 1'b0;
    logic dvld, tcchg, lpovl, sync, rhi;
    logic signed [23:0] dx, dsp;
    int num_errors = 0;
    int checked = 0;
    logic [31:0] d;
    // slope 24 dB in every row so the time constant stays out of the way
    lfs_row_t rows [9] = '{'{32'h300, 8'h00, 9'h000},
        '{32'h322, 8'h0E, 9'h00E}, '{32'h343, 8'h14, 9'h014},
        '{32'h31A, 8'h7C, 9'h07C}, '{32'h33A, 8'h9A, 9'h09A},
        '{32'h35A, 8'hAE, 9'h0AE}, '{32'h352, 8'h78, 9'h078},
        '{32'h709, 8'h0A, 9'h01E}, '{32'hB09, 8'h0A, 9'h032}};

    lfs_filter_ctrl #(.DISP_CYC(20), .AR_SETTLE_CYC(4)) lfs_filter_ctrl_i (
        .clk_sys_i(clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ref_freq_i(ref_f),
        .slot_tick_i(tick), .sample_vld_i(svld), .det_x_i(det),
        .reserve_overload_flag_i(rovl), .direct_x_o(dx), .direct_vld_o(dvld),
        .disp_x_o(dsp), .time_constant_changed_msg_o(tcchg),
        .lowpass_overload_flag_o(lpovl), .sync_active_o(sync),
        .range_hi_o(rhi));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic set_ref(input logic [23:0] f);
        @(posedge clk);
        ref_f <= f;
        repeat (4) @(posedge clk);
        #1;
    endtask

    // n detector samples, each with a slot tick
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk);
            svld <= 1'b1;
            tick <= 1'b1;
            @(posedge clk);
            svld <= 1'b0;
            tick <= 1'b0;
        end
        #1;
    endtask

    // starts auto reserve with the overload pin held, then checks the mode
    task automatic ar_run(input logic o, input logic [31:0] m);
        @(posedge clk);
        rovl <= o;
        wr_reg(lfs_pkg::LFS_A_CTRL, 32'h0000_2300);
        for (int k = 0; k < 40; k++) begin
            rd_reg(lfs_pkg::LFS_A_STAT, d);
            if (d[4] === 1'b0) break;
        end
        rd_reg(lfs_pkg::LFS_A_CTRL, d);
        chk(d & 32'h60, m);
    endtask

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #400000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd_reg(lfs_pkg::LFS_A_STAT, d);
        chk(d & 32'h3, 32'h0);
        foreach (rows[i]) begin
            wr_reg(lfs_pkg::LFS_A_CTRL, rows[i].ctrl);
            rd_reg(lfs_pkg::LFS_A_STAT, d);
            chk({24'h0, d[15:8]}, {24'h0, rows[i].res});
            rd_reg(lfs_pkg::LFS_A_GAIN, d);
            chk({23'h0, d[8:0]}, {23'h0, rows[i].gain});
        end
        // 12 dB, reserve 64, expand x10: gain 84 gives 100 us
        wr_reg(lfs_pkg::LFS_A_CTRL, 32'h0000_0511);
        rd_reg(lfs_pkg::LFS_A_STAT, d);
        chk({27'h0, d[20:16]}, 32'h2);
        wr_reg(lfs_pkg::LFS_A_CTRL, 32'h0000_0300);
        wr_reg(lfs_pkg::LFS_A_TC, 32'h0);
        rd_reg(lfs_pkg::LFS_A_TC, d);
        chk(d & 32'h1FFF, 32'h0200);
        wr_reg(lfs_pkg::LFS_A_CTRL, 32'h0000_035A);
        wr_reg(lfs_pkg::LFS_A_STAT, 32'h4);
        rd_reg(lfs_pkg::LFS_A_TC, d);
        chk(d & 32'h1FFF, 32'h0503);
        chk({31'h0, tcchg}, 32'h0);
        wr_reg(lfs_pkg::LFS_A_CTRL, 32'h0000_005A);
        rd_reg(lfs_pkg::LFS_A_TC, d);
        chk(d & 32'h1FFF, 32'h130D);
        chk({31'h0, tcchg}, 32'h1);
        // range hysteresis with harmonic 2 and sync enabled
        wr_reg(lfs_pkg::LFS_A_CTRL, 32'h0000_1300);
        wr_reg(lfs_pkg::LFS_A_HARM, 32'h2);
        wr_reg(lfs_pkg::LFS_A_TC, 32'h0F);
        wr_reg(lfs_pkg::LFS_A_STAT, 32'h4);
        chk({31'h0, sync}, 32'h1);
        set_ref(24'h0027AC);
        chk({31'h0, rhi}, 32'h0);
        set_ref(24'h0027AD);
        chk({31'h0, rhi}, 32'h1);
        chk({31'h0, sync}, 32'h0);
        chk({31'h0, tcchg}, 32'h1);
        rd_reg(lfs_pkg::LFS_A_TC, d);
        chk(d & 32'h1F, 32'h0D);
        wr_reg(lfs_pkg::LFS_A_TC, 32'h0E);
        rd_reg(lfs_pkg::LFS_A_TC, d);
        chk(d & 32'h1F, 32'h0D);
        set_ref(24'h0026E9);
        chk({31'h0, rhi}, 32'h1);
        set_ref(24'h0026E8);
        chk({30'h0, rhi, sync}, 32'h1);
        rd_reg(lfs_pkg::LFS_A_TC, d);
        chk(d & 32'h1F, 32'h0D);
        wr_reg(lfs_pkg::LFS_A_TC, 32'h13);
        wr_reg(lfs_pkg::LFS_A_TC, 32'h14);
        rd_reg(lfs_pkg::LFS_A_TC, d);
        chk(d & 32'h1F, 32'h13);
        ar_run(1'b1, 32'h40);
        ar_run(1'b0, 32'h0);
        wr_reg(lfs_pkg::LFS_A_TC, 32'h0);
        repeat (6) begin
            pulse(1);
            chk({30'h0, dvld, lpovl}, 32'h2);
        end
        chk({8'h0, dx}, 32'h100);
        repeat (25) @(posedge clk);
        #1;
        chk({8'h0, dsp}, 32'h100);
        // sync mean counts zeros while filling, then holds the full mean
        wr_reg(lfs_pkg::LFS_A_CTRL, 32'h0000_1300);
        pulse(67);
        chk({8'h0, dx}, 32'h80);
        pulse(67);
        chk({8'h0, dx}, 32'h100);
        wr_reg(lfs_pkg::LFS_A_CTRL, 32'h0000_0B00);
        @(posedge clk);
        det <= 24'sh10_0000;
        pulse(1);
        chk({31'h0, lpovl}, 32'h1);
        tally_and_finish();
    end
endmodule
